// ===== rtl/pin_function_pkg.sv
// shared constants and carrier types for the port pin function select block
package pin_function_pkg;

  // ************************************************************
  // register map (word index on the plain register port)
  // ************************************************************
  localparam logic [3:0] ADDR_PA_SEL1 = 4'h0;
  localparam logic [3:0] ADDR_PA_SEL2 = 4'h1;
  localparam logic [3:0] ADDR_PB_DIR = 4'h2;
  localparam logic [3:0] ADDR_PB_SEL_HI = 4'h3;
  localparam logic [3:0] ADDR_PB_SEL_LO = 4'h4;

  // ************************************************************
  // writable bit masks and reset values
  // ************************************************************
  localparam logic [15:0] MASK_PA_SEL1 = 16'h015F;
  localparam logic [15:0] MASK_PA_SEL2 = 16'hFD75;
  localparam logic [15:0] MASK_PB_DIR = 16'h03FF;
  localparam logic [15:0] MASK_PB_SEL_HI = 16'h000F;
  localparam logic [15:0] MASK_PB_SEL_LO = 16'hFFF5;
  localparam logic [15:0] RESET_VALUE = 16'h0000;

  // ************************************************************
  // field positions in select 1
  // ************************************************************
  localparam int POS_PA12 = 8;
  localparam int POS_PA11 = 6;
  localparam int POS_PA10 = 4;
  localparam int POS_PA9 = 2;
  localparam int POS_PA8 = 0;

  // ************************************************************
  // field positions in select 2
  // ************************************************************
  localparam int POS_PA7 = 14;
  localparam int POS_PA6 = 12;
  localparam int POS_PA5 = 10;
  localparam int POS_PA4 = 8;
  localparam int POS_PA3 = 6;
  localparam int POS_PA2 = 4;
  localparam int POS_PA1 = 2;
  localparam int POS_PA0 = 0;

  // ************************************************************
  // two-bit function codes
  // ************************************************************
  localparam logic [1:0] CODE_GPIO = 2'h0;
  localparam logic [1:0] CODE_ALT1 = 2'h1;
  localparam logic [1:0] CODE_ALT2 = 2'h2;
  localparam logic [1:0] CODE_ALT3 = 2'h3;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef enum logic [1:0] {
    MODE_SINGLE_CHIP,
    MODE_EXPANDED_ROM_ON,
    MODE_EXPANDED_ROM_OFF
  } op_mode_e;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  // per-pin routing of port a pins 0..12, one-hot meaning per pin
  typedef struct packed {
    logic [12:0] gpio;
    logic low_side_write_strobe;
    logic chip_select_zero;
    logic chip_select_one;
    logic chip_select_two;
    logic chip_select_three;
    logic timer_ext_clock_a;
    logic timer_ext_clock_b;
    logic timer_ext_clock_c;
    logic timer_ext_clock_d;
    logic [3:0] ext_interrupt_in;
    logic [1:0] dma_request_in;
    logic [1:0] serial_clock;
    logic [1:0] serial_tx;
    logic [1:0] serial_rx;
  } porta_route_s;

endpackage

// ===== rtl/port_pin_function_select.sv
// port a low pin function select and port b direction control
// ************************************************************
// Overview of operation
// (RULE1) reserved bits read zero, writes ignored
// (RULE2) pa12 select: gpio or low write strobe
// (RULE3) pa11 select: gpio or chip select one
// (RULE4) pa10 select: gpio or chip select zero
// (RULE5) operating mode overrides bus function selections
// (RULE6) pa9 field: gpio, timer clock d, ext_interrupt_in_3
// (RULE7) pa8 field: gpio, timer clock c, ext_interrupt_in_2
// (RULE8) pa7 field: gpio, timer clock b, cs3
// (RULE9) pa6 field: gpio, timer clock a, cs2
// (RULE10) pa5 field: gpio, serial_clock_ch1, dma_request_in_1, ext_interrupt_in_1
// (RULE11) pa4 select: gpio or serial tx1
// (RULE12) pa3 select: gpio or serial rx1
// (RULE13) pa2 field: gpio, serial_clock_ch0, dma_request_in_0, ext_interrupt_in_0
// (RULE14) pa1 select: gpio or serial tx0
// (RULE15) pa0 select: gpio or serial rx0
// (RULE16) port b gpio: direction one drives output
// (RULE17) direction ignored for non-gpio port b pins
// (RULE18) direction register sixteen bits, ten used
// (RULE19) direction cleared only by power-on reset
// (RULE20) port b selects cleared only by power-on
// (RULE21) mode may override port b bus functions
// (RULE22) high select: pins 9-8; low: 7-0
// (RULE23) port a select 2 cleared only power-on
// (RULE24) software never writes reserved code 11
// (RULE25) new routing takes effect next cycle, glitch-free
// ************************************************************
`timescale 1ns/1ps

module port_pin_function_select (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire pin_function_pkg::op_mode_e op_mode_i,
  output logic [15:0] reg_rdata_o,
  output pin_function_pkg::porta_route_s porta_route_o,
  output logic [9:0] portb_gpio_o,
  output logic [9:0] portb_oe_o,
  output logic [15:0] portb_function_select_high_o,
  output logic [15:0] portb_function_select_low_o
);
  import pin_function_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [15:0] pa_sel1;
    logic [15:0] pa_sel2;
    logic [15:0] pb_dir;
    logic [15:0] pb_sel_hi;
    logic [15:0] pb_sel_lo;
    logic [15:0] rdata;
    op_mode_e mode;
    porta_route_s route;
    logic [9:0] pb_gpio;
    logic [9:0] pb_oe;
  } state_s;

  state_s state_reg;
  state_s state_next;
  reg_req_s req;

  assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [1:0] field2(input logic [15:0] r, input int pos);
    field2 = r[pos+:2];
  endfunction

  // bus function: single chip forbids, rom-off expanded forces
  function automatic logic bus_fn(input logic sel, input op_mode_e m);
    unique case (m)
      MODE_SINGLE_CHIP: bus_fn = 1'b0;
      MODE_EXPANDED_ROM_OFF: bus_fn = 1'b1;
      MODE_EXPANDED_ROM_ON: bus_fn = sel;
      default: bus_fn = 1'b0;
    endcase
  endfunction

  // port b pin is gpio when its field holds zero
  function automatic logic [9:0] pb_is_gpio(input logic [15:0] hi, input logic [15:0] lo);
    pb_is_gpio[9] = (hi[3:2] == CODE_GPIO);
    pb_is_gpio[8] = (hi[1:0] == CODE_GPIO);
    pb_is_gpio[7] = (lo[15:14] == CODE_GPIO);
    pb_is_gpio[6] = (lo[13:12] == CODE_GPIO);
    pb_is_gpio[5] = (lo[11:10] == CODE_GPIO);
    pb_is_gpio[4] = (lo[9:8] == CODE_GPIO);
    pb_is_gpio[3] = (lo[7:6] == CODE_GPIO);
    pb_is_gpio[2] = (lo[5:4] == CODE_GPIO);
    pb_is_gpio[1] = ~lo[2];
    pb_is_gpio[0] = ~lo[0];
  endfunction

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    logic [15:0] s1;
    logic [15:0] s2;
    logic [15:0] ph;
    logic [15:0] pl;
    logic [15:0] pd;
    logic expanded;
    porta_route_s r;
    s1 = state_reg.pa_sel1;
    s2 = state_reg.pa_sel2;
    ph = state_reg.pb_sel_hi;
    pl = state_reg.pb_sel_lo;
    pd = state_reg.pb_dir;
    expanded = 1'b0;
    r = '0;
    state_next = state_reg;
    state_next.mode = op_mode_i;

    // writes keep only the writable bits
    if (req.wr) begin
      unique case (req.addr)
        ADDR_PA_SEL1: state_next.pa_sel1 = req.wdata & MASK_PA_SEL1; // RULE1
        ADDR_PA_SEL2: state_next.pa_sel2 = req.wdata & MASK_PA_SEL2; // RULE1
        ADDR_PB_DIR: state_next.pb_dir = req.wdata & MASK_PB_DIR; // RULE18
        ADDR_PB_SEL_HI: state_next.pb_sel_hi = req.wdata & MASK_PB_SEL_HI; // RULE22
        ADDR_PB_SEL_LO: state_next.pb_sel_lo = req.wdata & MASK_PB_SEL_LO; // RULE22
        default: ;
      endcase
    end

    // read data stands one cycle after the strobe only
    state_next.rdata = '0;
    if (req.rd) begin
      unique case (req.addr)
        ADDR_PA_SEL1: state_next.rdata = s1;
        ADDR_PA_SEL2: state_next.rdata = s2;
        ADDR_PB_DIR: state_next.rdata = pd;
        ADDR_PB_SEL_HI: state_next.rdata = ph;
        ADDR_PB_SEL_LO: state_next.rdata = pl;
        default: state_next.rdata = '0;
      endcase
    end

    // routing from registered settings, updated as whole registers
    expanded = (state_reg.mode != MODE_SINGLE_CHIP);
    r.low_side_write_strobe = bus_fn(s1[POS_PA12], state_reg.mode); // RULE2 RULE5
    r.chip_select_one = bus_fn(s1[POS_PA11], state_reg.mode); // RULE3 RULE5
    r.chip_select_zero = bus_fn(s1[POS_PA10], state_reg.mode); // RULE4 RULE5
    r.timer_ext_clock_d = (field2(s1, POS_PA9) == CODE_ALT1); // RULE6
    r.ext_interrupt_in[3] = (field2(s1, POS_PA9) == CODE_ALT2); // RULE6
    r.timer_ext_clock_c = (field2(s1, POS_PA8) == CODE_ALT1); // RULE7
    r.ext_interrupt_in[2] = (field2(s1, POS_PA8) == CODE_ALT2); // RULE7
    r.timer_ext_clock_b = (field2(s2, POS_PA7) == CODE_ALT1); // RULE8
    r.chip_select_three = expanded && (field2(s2, POS_PA7) == CODE_ALT2); // RULE8 RULE5
    r.timer_ext_clock_a = (field2(s2, POS_PA6) == CODE_ALT1); // RULE9
    r.chip_select_two = expanded && (field2(s2, POS_PA6) == CODE_ALT2); // RULE9 RULE5
    r.serial_clock[1] = (field2(s2, POS_PA5) == CODE_ALT1); // RULE10
    r.dma_request_in[1] = expanded && (field2(s2, POS_PA5) == CODE_ALT2); // RULE10
    r.ext_interrupt_in[1] = (field2(s2, POS_PA5) == CODE_ALT3); // RULE10
    r.serial_tx[1] = s2[POS_PA4]; // RULE11
    r.serial_rx[1] = s2[POS_PA3]; // RULE12
    r.serial_clock[0] = (field2(s2, POS_PA2) == CODE_ALT1); // RULE13
    r.dma_request_in[0] = expanded && (field2(s2, POS_PA2) == CODE_ALT2); // RULE13
    r.ext_interrupt_in[0] = (field2(s2, POS_PA2) == CODE_ALT3); // RULE13
    r.serial_tx[0] = s2[POS_PA1]; // RULE14
    r.serial_rx[0] = s2[POS_PA0]; // RULE15

    // pin is gpio when nothing else claims it; reserved 11 falls back to gpio
    r.gpio[12] = ~r.low_side_write_strobe;
    r.gpio[11] = ~r.chip_select_one;
    r.gpio[10] = ~r.chip_select_zero;
    r.gpio[9] = ~(r.timer_ext_clock_d | r.ext_interrupt_in[3]); // RULE24
    r.gpio[8] = ~(r.timer_ext_clock_c | r.ext_interrupt_in[2]); // RULE24
    r.gpio[7] = ~(r.timer_ext_clock_b | r.chip_select_three); // RULE24
    r.gpio[6] = ~(r.timer_ext_clock_a | r.chip_select_two); // RULE24
    r.gpio[5] = ~(r.serial_clock[1] | r.dma_request_in[1] | r.ext_interrupt_in[1]);
    r.gpio[4] = ~r.serial_tx[1];
    r.gpio[3] = ~r.serial_rx[1];
    r.gpio[2] = ~(r.serial_clock[0] | r.dma_request_in[0] | r.ext_interrupt_in[0]);
    r.gpio[1] = ~r.serial_tx[0];
    r.gpio[0] = ~r.serial_rx[0];
    state_next.route = r; // RULE25

    // port b: direction only for gpio pins; mode gating left to pin logic
    state_next.pb_gpio = pb_is_gpio(ph, pl); // RULE21
    state_next.pb_oe = pd[9:0] & pb_is_gpio(ph, pl); // RULE16 RULE17

    // power-on reset only; other resets and low power never reach here
    if (!rst_n_i) begin
      state_next = '0;
      state_next.pa_sel1 = RESET_VALUE; // RULE19 RULE20 RULE23
      state_next.pa_sel2 = RESET_VALUE; // RULE23
      state_next.pb_dir = RESET_VALUE; // RULE19
      state_next.pb_sel_hi = RESET_VALUE; // RULE20
      state_next.pb_sel_lo = RESET_VALUE; // RULE20
      state_next.pb_gpio = '1;
      state_next.route.gpio = '1;
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge clock_i) begin
    state_reg <= state_next;
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign reg_rdata_o = state_reg.rdata;
  assign porta_route_o = state_reg.route;
  assign portb_gpio_o = state_reg.pb_gpio;
  assign portb_oe_o = state_reg.pb_oe;
  assign portb_function_select_high_o = state_reg.pb_sel_hi;
  assign portb_function_select_low_o = state_reg.pb_sel_lo;

endmodule

// ===== verif/pin_function_properties.sv
// port-level assertions for the pin function select block
`timescale 1ns/1ps
module pin_function_properties (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire pin_function_pkg::op_mode_e op_mode_i,
  input wire logic [15:0] reg_rdata_o,
  input wire pin_function_pkg::porta_route_s porta_route_o,
  input wire logic [9:0] portb_gpio_o,
  input wire logic [9:0] portb_oe_o,
  input wire logic [15:0] portb_function_select_high_o,
  input wire logic [15:0] portb_function_select_low_o
);
  import pin_function_pkg::*;
  logic [15:0] wd_q, w;
  logic [3:0] wa_q, wa_qq;
  logic wv_q, wv_qq;
  op_mode_e md_q, md_qq;
  // write and mode seen two edges back
  always_ff @(posedge clock_i) begin
    wd_q <= reg_wdata_i;
    w <= wd_q;
    wa_q <= reg_addr_i;
    wa_qq <= wa_q;
    md_q <= op_mode_i;
    md_qq <= md_q;
    wv_q <= rst_n_i & reg_wr_i;
    wv_qq <= rst_n_i & wv_q;
  end
  wire sc = (md_qq == MODE_SINGLE_CHIP);
  wire ro = (md_qq == MODE_EXPANDED_ROM_OFF);
  // one bit per register index written two edges back
  wire [15:0] whit = wv_qq ? 16'h0001 << wa_qq : 16'h0000;
  function automatic logic [15:0] rsv(input logic [3:0] a);
    case (a)
      ADDR_PA_SEL1: return ~MASK_PA_SEL1;
      ADDR_PA_SEL2: return ~MASK_PA_SEL2;
      ADDR_PB_DIR: return ~MASK_PB_DIR;
      ADDR_PB_SEL_HI: return ~MASK_PB_SEL_HI;
      ADDR_PB_SEL_LO: return ~MASK_PB_SEL_LO;
      default: return 16'hFFFF;
    endcase
  endfunction
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  rsv_read_zero_a: assert property ($past(reg_rd_i) |->
    (reg_rdata_o & rsv($past(reg_addr_i))) == 16'h0000) else $error("reserved bits read set");
  oe_needs_gpio_a: assert property ((portb_oe_o & ~portb_gpio_o) == 10'h000)
    else $error("port b drive on non-gpio pin");
  dir_to_oe_a: assert property (whit[ADDR_PB_DIR] |->
    portb_oe_o == (w[9:0] & portb_gpio_o)) else $error("port b enable wrong");
  bus_strobe_a: assert property (whit[ADDR_PA_SEL1] |->
    {porta_route_o.low_side_write_strobe, porta_route_o.chip_select_one,
     porta_route_o.chip_select_zero} == (sc ? 3'h0 : ro ? 3'h7 : {w[8], w[6], w[4]}))
    else $error("strobe routing wrong");
  timer_irq_hi_a: assert property (whit[ADDR_PA_SEL1] |->
    {porta_route_o.timer_ext_clock_d, porta_route_o.ext_interrupt_in[3],
     porta_route_o.timer_ext_clock_c, porta_route_o.ext_interrupt_in[2]}
    == {w[3:2] == 2'h1, w[3:2] == 2'h2, w[1:0] == 2'h1, w[1:0] == 2'h2})
    else $error("pin 9/8 routing wrong");
  serial_data_a: assert property (whit[ADDR_PA_SEL2] |->
    {porta_route_o.serial_tx, porta_route_o.serial_rx} == {w[8], w[2], w[6], w[0]})
    else $error("serial data routing wrong");
  pa5_pa2_a: assert property (whit[ADDR_PA_SEL2] |->
    {porta_route_o.serial_clock, porta_route_o.ext_interrupt_in[1:0],
     porta_route_o.dma_request_in} == {w[11:10] == 2'h1, w[5:4] == 2'h1, w[11:10] == 2'h3,
     w[5:4] == 2'h3, w[11:10] == 2'h2 && !sc, w[5:4] == 2'h2 && !sc})
    else $error("pin 5/2 routing wrong");
  chip_sel_lo_a: assert property (whit[ADDR_PA_SEL2] |->
    {porta_route_o.chip_select_three, porta_route_o.chip_select_two}
    == {w[15:14] == 2'h2 && !sc, w[13:12] == 2'h2 && !sc}) else $error("cs2/cs3 wrong");
  pb_gpio_hi_a: assert property (whit[ADDR_PB_SEL_HI] |->
    portb_gpio_o[9:8] == {w[3:2] == 2'h0, w[1:0] == 2'h0}) else $error("pins 9/8 gpio wrong");
  reset_clear_a: assert property ($rose(rst_n_i) |-> portb_oe_o == 10'h000 &&
    porta_route_o.gpio == 13'h1FFF && (portb_function_select_high_o
    | portb_function_select_low_o) == 16'h0000) else $error("reset state wrong");
endmodule
bind port_pin_function_select pin_function_properties u_props (.clock_i, .rst_n_i,
  .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .op_mode_i, .reg_rdata_o, .porta_route_o,
  .portb_gpio_o, .portb_oe_o, .portb_function_select_high_o, .portb_function_select_low_o);

// ===== verif/pin_pads.sv
// port b pad model: device drives enabled pins, outside world the rest
`timescale 1ns/1ps
module pin_pads (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [9:0] oe_i,
  input wire logic [9:0] dev_level_i,
  output logic [9:0] pad_o
);
  logic [9:0] ext_reg;
  // outside level toggles so a stale value never looks driven
  always_ff @(posedge clock_i) begin
    ext_reg <= rst_n_i ? ~ext_reg : 10'h155;
  end
  assign pad_o = (oe_i & dev_level_i) | (~oe_i & ext_reg);
endmodule

// ===== verif/tb_top.sv
// register-level bench for the pin function select block
`timescale 1ns/1ps
module tb_top;
  import pin_function_pkg::*;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [3:0] reg_addr_i = 4'h0;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  op_mode_e op_mode_i = MODE_EXPANDED_ROM_ON;
  logic [15:0] reg_rdata_o, d, pb_hi, pb_lo;
  porta_route_s r;
  logic [9:0] portb_gpio_o, portb_oe_o, pad;
  logic [15:0] msk [6] = '{MASK_PA_SEL1, MASK_PA_SEL2, MASK_PB_DIR, MASK_PB_SEL_HI,
    MASK_PB_SEL_LO, 16'h0000};
  int n_mismatch = 0;
  int tests_run = 0;
  always #5 clock_i = ~clock_i;
  port_pin_function_select uut (.clock_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .op_mode_i, .reg_rdata_o, .porta_route_o(r), .portb_gpio_o, .portb_oe_o,
    .portb_function_select_high_o(pb_hi), .portb_function_select_low_o(pb_lo));
  pin_pads party (.clock_i, .rst_n_i, .oe_i(portb_oe_o), .dev_level_i(10'h2A5), .pad_o(pad));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    @(negedge clock_i);
    chk(reg_rdata_o, exp);
  endtask
  // routing outputs launch one edge after the write edge
  task automatic settle;
    @(posedge clock_i);
    @(negedge clock_i);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #100000;
    n_mismatch++;
    give_verdict();
  end
  initial begin
    repeat (8) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(posedge clock_i);
    for (int a = 0; a < 6; a++) rd(4'(a), 16'h0000);
    chk({6'h00, portb_gpio_o}, 16'h03FF);
    for (int p = 0; p < 2; p++) begin
      for (int a = 0; a < 6; a++) begin
        d = p ? 16'hAAAA : 16'h5555;
        wr(4'(a), d);
        rd(4'(a), d & msk[a]);
      end
    end
    $display("test reset and masks done");
    for (int m = 0; m < 3; m++) begin
      for (int c = 0; c < 3; c++) begin
        @(posedge clock_i);
        op_mode_i <= op_mode_e'(m);
        wr(ADDR_PA_SEL1, (c != 0 ? 16'h0150 : 16'h0000) | 16'(c * 5));
        settle();
        chk({r.low_side_write_strobe, r.chip_select_one, r.chip_select_zero},
          (m == 0) ? 3'h0 : (m == 2 || c != 0) ? 3'h7 : 3'h0);
        chk({r.timer_ext_clock_d, r.timer_ext_clock_c, r.ext_interrupt_in[3:2]},
          {{2{c == 1}}, {2{c == 2}}});
        d = 16'(c << 10 | c << 4) | (c[0] ? 16'h0145 : 16'h0000);
        wr(ADDR_PA_SEL2, d);
        wr(ADDR_PA_SEL2, d | 16'(c << 14 | c << 12));
        settle();
        chk({2'h0, r.serial_clock, r.ext_interrupt_in[1:0], r.dma_request_in,
          r.chip_select_three, r.chip_select_two, r.timer_ext_clock_b, r.timer_ext_clock_a,
          r.serial_tx, r.serial_rx}, {2'h0, {2{c == 1}}, 2'h0, {4{c == 2 && m != 0}},
          {2{c == 1}}, {4{c[0]}}});
        wr(ADDR_PA_SEL2, 16'h0C30);
        settle();
        chk({14'h0, r.ext_interrupt_in[1:0]}, 16'h0003);
        chk({3'h0, r.gpio}, {3'h0, (m == 2 || (m == 1 && c != 0)) ? 3'h0 : 3'h7,
          {2{c == 0}}, 8'hDB});
      end
    end
    @(posedge clock_i);
    op_mode_i <= MODE_EXPANDED_ROM_ON;
    $display("test port a routing done");
    wr(ADDR_PB_SEL_LO, 16'h0004);
    wr(ADDR_PB_SEL_HI, 16'h0008);
    wr(ADDR_PB_DIR, 16'hFFFF);
    settle();
    chk({6'h00, portb_oe_o}, 16'h01FD);
    chk({6'h00, pad & portb_oe_o}, 16'h00A5);
    chk(pb_hi, 16'h0008);
    chk(pb_lo, 16'h0004);
    @(posedge clock_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(posedge clock_i);
    rd(ADDR_PB_DIR, 16'h0000);
    rd(ADDR_PA_SEL2, 16'h0000);
    $display("test port b and reset done");
    give_verdict();
  end
endmodule
